// ==== dual_excl_defs.vh ====
// Constants for the dual-word and exclusive load execution block.
// Assumes 32-bit two-halfword instruction encodings with halfword 1 in bits 15:0.
`ifndef DUAL_EXCL_DEFS_VH
`define DUAL_EXCL_DEFS_VH

// First halfword opcode fields (bits 15:0 of instr_i), plus the narrow exclusive sub-opcodes for bits 23:20
`define OP_HI_MSB        15
`define OP_HI_LSB        9
`define OP_DUAL_HI       7'h74
`define OP_EXCL_WORD     12'hE85
`define OP_EXCL_NARROW   12'hE8D
`define OP_EXCL_SUB_BYTE 4'h4
`define OP_EXCL_SUB_HALF 4'h5
`define BIT_P            8
`define BIT_U            7
`define BIT_FIXED6       6
`define BIT_W            5
`define BIT_LOAD         4
// Operand fields (in instr_i bit numbering): Rn in the first halfword, the rest in the second
`define FLD_RN_MSB       3
`define FLD_RN_LSB       0
`define FLD_RT_MSB       31
`define FLD_RT_LSB       28
`define FLD_RT2_MSB      27
`define FLD_RT2_LSB      24
`define FLD_OFFSET_FIELD_MSB     23
`define FLD_OFFSET_FIELD_LSB     16
`define FLD_SUB_MSB      23
`define FLD_SUB_LSB      20
// Register numbers
`define REG_SP           4'hD
`define REG_PC           4'hF
// Access sizes in bytes
`define SIZE_WORD        3'h4
`define SIZE_HALF        3'h2
`define SIZE_BYTE        3'h1
`define WORD_STEP        32'h00000004
// Operation kinds
`define KIND_NONE        3'h0
`define KIND_DUAL_IMM    3'h1
`define KIND_DUAL_LIT    3'h2
`define KIND_EXCL_WORD   3'h3
`define KIND_EXCL_BYTE   3'h4
`define KIND_EXCL_HALF   3'h5

`endif

// ==== load_decode.v ====
// Combinational decoder for dual-word and exclusive loads.
// Assumes instr_i holds a full 32-bit encoding, first halfword in bits 15:0.
`timescale 1ns/1ps
`default_nettype none
`include "dual_excl_defs.vh"
module load_decode (
    input  wire [31:0] instr_i,
    output reg  [2:0]  kind_o,
    output wire [3:0]  first_dest_reg_o,
    output wire [3:0]  second_dest_reg_o,
    output wire [3:0]  base_reg_o,
    output wire [31:0] expanded_offset_o,
    output wire        index_o,
    output wire        add_o,
    output wire        wback_o,
    output reg         unpredictable_o,
    output wire        related_o
);
    wire [3:0] rt  = instr_i[`FLD_RT_MSB:`FLD_RT_LSB];
    wire [3:0] rt2 = instr_i[`FLD_RT2_MSB:`FLD_RT2_LSB];
    wire [3:0] rn  = instr_i[`FLD_RN_MSB:`FLD_RN_LSB];
    wire [7:0] offset_field = instr_i[`FLD_OFFSET_FIELD_MSB:`FLD_OFFSET_FIELD_LSB];
    wire       p_bit = instr_i[`BIT_P];
    wire       w_bit = instr_i[`BIT_W];
    wire       dual_shape = (instr_i[`OP_HI_MSB:`OP_HI_LSB] == `OP_DUAL_HI) &&
                            instr_i[`BIT_FIXED6] && instr_i[`BIT_LOAD];
    wire [11:0] top12 = instr_i[15:4];
    wire [3:0]  excl_sub = instr_i[`FLD_SUB_MSB:`FLD_SUB_LSB];
    wire        excl_hit = (top12 == `OP_EXCL_WORD) ||
                           ((top12 == `OP_EXCL_NARROW) &&
                            ((excl_sub == `OP_EXCL_SUB_BYTE) || (excl_sub == `OP_EXCL_SUB_HALF)));

    function sp_or_pc;
        input [3:0] r;
        begin
            sp_or_pc = (r == `REG_SP) || (r == `REG_PC);
        end
    endfunction

    assign first_dest_reg_o  = rt;
    assign second_dest_reg_o = rt2;
    assign base_reg_o        = rn;
    assign expanded_offset_o = {22'h000000, offset_field, 2'h0};
    assign index_o = (p_bit == 1'b1);
    assign add_o   = (instr_i[`BIT_U] == 1'b1);
    assign wback_o = (w_bit == 1'b1);
    // route to related group
    // Exclusive loads sit in that group but are executed here, so they are not routed away
    assign related_o = dual_shape && !p_bit && !w_bit && !excl_hit;

    always @* begin
        kind_o = `KIND_NONE;
        unpredictable_o = 1'b0;
        if (dual_shape && (p_bit || w_bit)) begin
            if (rn == `REG_PC) begin
                kind_o = `KIND_DUAL_LIT;
                unpredictable_o = sp_or_pc(rt) || sp_or_pc(rt2) || (rt == rt2) || w_bit;
            end else begin
                kind_o = `KIND_DUAL_IMM;
                unpredictable_o = (w_bit && ((rn == rt) || (rn == rt2))) ||
                                  sp_or_pc(rt) || sp_or_pc(rt2) || (rt == rt2);
            end
        end else if (top12 == `OP_EXCL_WORD) begin
            kind_o = `KIND_EXCL_WORD;
            unpredictable_o = sp_or_pc(rt) || (rn == `REG_PC);
        end else if (top12 == `OP_EXCL_NARROW) begin
            if (instr_i[`FLD_SUB_MSB:`FLD_SUB_LSB] == `OP_EXCL_SUB_BYTE) begin
                kind_o = `KIND_EXCL_BYTE;
                unpredictable_o = sp_or_pc(rt) || (rn == `REG_PC);
            end else if (instr_i[`FLD_SUB_MSB:`FLD_SUB_LSB] == `OP_EXCL_SUB_HALF) begin
                kind_o = `KIND_EXCL_HALF;
                unpredictable_o = sp_or_pc(rt) || (rn == `REG_PC);
            end
        end
    end
endmodule // load_decode
`default_nettype wire

// ==== load_exec.v ====
// Execution sequencer for dual-word and exclusive loads.
// Assumes a single-cycle-request memory port that answers with mem_rvalid_i later.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dual_excl_defs.vh"
module load_exec (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        issue_i,
    input  wire [31:0] instr_i,
    input  wire        condition_check_i,
    input  wire [31:0] pc_i,
    input  wire [31:0] base_value_i,
    input  wire [31:0] mem_rdata_i,
    input  wire        mem_rvalid_i,
    input  wire        mem_shareable_i,
    output reg         busy_o,
    output reg         done_o,
    output reg         related_o,
    output reg         unpredictable_o,
    output reg         align_fault_o,
    output reg         mem_req_o,
    output reg  [31:0] mem_addr_o,
    output reg  [2:0]  mem_size_o,
    output reg         reg_we_o,
    output reg  [3:0]  reg_waddr_o,
    output reg  [31:0] reg_wdata_o,
    output reg         arm_exclusive_monitors_o,
    output reg         global_mark_o,
    output reg         local_excl_o,
    output reg  [31:0] local_addr_o,
    output reg  [2:0]  local_size_o
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_WAIT1  = 3'h1;
    localparam [2:0] ST_REQ2   = 3'h2;
    localparam [2:0] ST_WAIT2  = 3'h3;
    localparam [2:0] ST_WBACK  = 3'h4;

    wire [2:0]  kind;
    wire [3:0]  rt;
    wire [3:0]  rt2;
    wire [3:0]  rn;
    wire [31:0] imm;
    wire        f_index;
    wire        f_add;
    wire        f_wback;
    wire        dec_unpred;
    wire        dec_related;

    load_decode u_decode (
        .instr_i           (instr_i),
        .kind_o            (kind),
        .first_dest_reg_o  (rt),
        .second_dest_reg_o (rt2),
        .base_reg_o        (rn),
        .expanded_offset_o (imm),
        .index_o           (f_index),
        .add_o             (f_add),
        .wback_o           (f_wback),
        .unpredictable_o   (dec_unpred),
        .related_o         (dec_related)
    );

    function misaligned;
        input [31:0] a;
        input [2:0]  sz;
        begin
            misaligned = ((sz == `SIZE_WORD) && (a[1:0] != 2'h0)) ||
                         ((sz == `SIZE_HALF) && a[0]);
        end
    endfunction

    reg  [2:0]  state_q;
    reg  [2:0]  kind_q;
    reg  [3:0]  rt_q;
    reg  [3:0]  rt2_q;
    reg  [3:0]  rn_q;
    reg  [31:0] addr_q;
    reg  [31:0] offset_addr_q;
    reg         wback_q;

    wire [31:0] offset_addr = f_add ? (base_value_i + imm) : (base_value_i - imm);
    wire [31:0] lit_addr    = f_add ? (pc_i + imm) : (pc_i - imm);
    reg  [31:0] start_addr;
    reg  [2:0]  start_size;
    reg         start_unpred;

    always @* begin
        start_addr   = base_value_i;
        start_size   = `SIZE_WORD;
        start_unpred = dec_unpred;
        case (kind)
            `KIND_DUAL_IMM: begin
                start_addr = f_index ? offset_addr : base_value_i;
            end
            `KIND_DUAL_LIT: begin
                start_addr = lit_addr;
                start_unpred = dec_unpred || (pc_i[1:0] != 2'h0);
            end
            `KIND_EXCL_WORD: begin
                start_addr = base_value_i + imm;
            end
            `KIND_EXCL_BYTE: begin
                start_size = `SIZE_BYTE;
            end
            `KIND_EXCL_HALF: begin
                start_size = `SIZE_HALF;
            end
            default: begin
                start_addr = base_value_i;
            end
        endcase
    end

    wire is_excl = (kind == `KIND_EXCL_WORD) || (kind == `KIND_EXCL_BYTE) || (kind == `KIND_EXCL_HALF);
    wire is_dual = (kind == `KIND_DUAL_IMM) || (kind == `KIND_DUAL_LIT);
    wire launch  = issue_i && condition_check_i && !busy_o && (is_excl || is_dual);
    wire fault   = misaligned(start_addr, start_size);
    wire [31:0] second_addr = addr_q + `WORD_STEP;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q                  <= ST_IDLE;
            kind_q                   <= `KIND_NONE;
            rt_q                     <= 4'h0;
            rt2_q                    <= 4'h0;
            rn_q                     <= 4'h0;
            addr_q                   <= 32'h00000000;
            offset_addr_q            <= 32'h00000000;
            wback_q                  <= 1'b0;
            busy_o                   <= 1'b0;
            done_o                   <= 1'b0;
            related_o                <= 1'b0;
            unpredictable_o          <= 1'b0;
            align_fault_o            <= 1'b0;
            mem_req_o                <= 1'b0;
            mem_addr_o               <= 32'h00000000;
            mem_size_o               <= 3'h0;
            reg_we_o                 <= 1'b0;
            reg_waddr_o              <= 4'h0;
            reg_wdata_o              <= 32'h00000000;
            arm_exclusive_monitors_o <= 1'b0;
            global_mark_o            <= 1'b0;
            local_excl_o             <= 1'b0;
            local_addr_o             <= 32'h00000000;
            local_size_o             <= 3'h0;
        end else begin
            done_o                   <= 1'b0;
            related_o                <= 1'b0;
            unpredictable_o          <= 1'b0;
            align_fault_o            <= 1'b0;
            mem_req_o                <= 1'b0;
            reg_we_o                 <= 1'b0;
            arm_exclusive_monitors_o <= 1'b0;
            global_mark_o            <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (issue_i && condition_check_i && dec_related) begin
                        related_o <= 1'b1;
                    end else if (launch && fault) begin
                        unpredictable_o <= start_unpred;
                        align_fault_o <= 1'b1;
                        done_o        <= 1'b1;
                    end else if (launch) begin
                        // Unpredictable cases are flagged but still executed deterministically
                        unpredictable_o <= start_unpred;
                        kind_q          <= kind;
                        rt_q            <= rt;
                        rt2_q           <= rt2;
                        rn_q            <= rn;
                        addr_q          <= start_addr;
                        offset_addr_q   <= offset_addr;
                        wback_q         <= (kind == `KIND_DUAL_IMM) && f_wback;
                        mem_req_o       <= 1'b1;
                        mem_addr_o      <= start_addr;
                        mem_size_o      <= start_size;
                        busy_o          <= 1'b1;
                        state_q         <= ST_WAIT1;
                        if (is_excl) begin
                            arm_exclusive_monitors_o <= 1'b1;
                            local_excl_o             <= 1'b1;
                            local_addr_o             <= start_addr;
                            local_size_o             <= start_size;
                            global_mark_o            <= mem_shareable_i;
                        end
                    end
                end
                ST_WAIT1: begin
                    if (mem_rvalid_i) begin
                        reg_we_o    <= 1'b1;
                        reg_waddr_o <= rt_q;
                        case (mem_size_o)
                            `SIZE_BYTE: reg_wdata_o <= {24'h000000, mem_rdata_i[7:0]};
                            `SIZE_HALF: reg_wdata_o <= {16'h0000, mem_rdata_i[15:0]};
                            default:    reg_wdata_o <= mem_rdata_i;
                        endcase
                        if ((kind_q == `KIND_DUAL_IMM) || (kind_q == `KIND_DUAL_LIT)) begin
                            state_q <= ST_REQ2;
                        end else begin
                            busy_o  <= 1'b0;
                            done_o  <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_REQ2: begin
                    mem_req_o  <= 1'b1;
                    mem_addr_o <= second_addr;
                    mem_size_o <= `SIZE_WORD;
                    state_q    <= ST_WAIT2;
                end
                ST_WAIT2: begin
                    if (mem_rvalid_i) begin
                        reg_we_o    <= 1'b1;
                        reg_waddr_o <= rt2_q;
                        reg_wdata_o <= mem_rdata_i;
                        if (wback_q) begin
                            state_q <= ST_WBACK;
                        end else begin
                            busy_o  <= 1'b0;
                            done_o  <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_WBACK: begin
                    reg_we_o    <= 1'b1;
                    reg_waddr_o <= rn_q;
                    reg_wdata_o <= offset_addr_q;
                    busy_o      <= 1'b0;
                    done_o      <= 1'b1;
                    state_q     <= ST_IDLE;
                end
                default: begin
                    busy_o  <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // load_exec
`default_nettype wire

// ==== load_exec_sva.sv ====
// Port checker for the dual and exclusive load sequencer.
// Assumes it is bound to load_exec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module load_exec_sva (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire        issue_i,
    input wire        condition_check_i,
    input wire        mem_rvalid_i,
    input wire        mem_shareable_i,
    input wire        busy_o,
    input wire        done_o,
    input wire        related_o,
    input wire        align_fault_o,
    input wire        mem_req_o,
    input wire [31:0] mem_addr_o,
    input wire [2:0]  mem_size_o,
    input wire        reg_we_o,
    input wire        arm_exclusive_monitors_o,
    input wire        global_mark_o,
    input wire        local_excl_o,
    input wire [31:0] local_addr_o,
    input wire [2:0]  local_size_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    reg        pend_q;
    reg [31:0] first_q;
    // Dual loads are told apart from exclusives by the missing arm pulse
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'h0;
            first_q <= 32'h0;
        end else if (done_o) begin
            pend_q <= 1'h0;
        end else if (mem_req_o && !arm_exclusive_monitors_o) begin
            pend_q <= !pend_q;
            first_q <= mem_addr_o;
        end
    end
    sequence s_refused;
        issue_i && !condition_check_i && !busy_o;
    endsequence
    sequence s_quiet;
        !mem_req_o && !reg_we_o && !arm_exclusive_monitors_o;
    endsequence
    cond_gate_a: assert property (s_refused |=> s_quiet)
        else $error("Refused issue had an effect");
    req_busy_a: assert property (mem_req_o |-> busy_o && mem_size_o inside {3'h1, 3'h2, 3'h4})
        else $error("Bad read request");
    rvalid_write_a: assert property (mem_rvalid_i && busy_o |=> reg_we_o)
        else $error("Read data not written");
    second_word_a: assert property (mem_req_o && !arm_exclusive_monitors_o && pend_q
        |-> mem_addr_o == first_q + 32'h4) else $error("Second word address wrong");
    arm_record_a: assert property (arm_exclusive_monitors_o |-> mem_req_o && local_excl_o
        && local_addr_o == mem_addr_o && local_size_o == mem_size_o) else $error("Monitor record wrong");
    global_mark_a: assert property (arm_exclusive_monitors_o || global_mark_o
        |-> global_mark_o == (arm_exclusive_monitors_o && $past(mem_shareable_i))) else $error("Global mark wrong");
    word_align_a: assert property (mem_req_o && mem_size_o == 3'h4 |-> mem_addr_o[1:0] == 2'h0)
        else $error("Misaligned word read");
    half_align_a: assert property (mem_req_o && mem_size_o == 3'h2 |-> !mem_addr_o[0])
        else $error("Misaligned half read");
    fault_stop_a: assert property (align_fault_o |-> done_o && !mem_req_o && !reg_we_o)
        else $error("Fault did not stop access");
    related_idle_a: assert property (related_o |-> !busy_o && !mem_req_o)
        else $error("Related encoding executed");
endmodule // load_exec_sva
bind load_exec load_exec_sva chk_u (
    .clock_i, .rst_n_i, .issue_i, .condition_check_i, .mem_rvalid_i, .mem_shareable_i, .busy_o, .done_o,
    .related_o, .align_fault_o, .mem_req_o, .mem_addr_o, .mem_size_o, .reg_we_o, .arm_exclusive_monitors_o,
    .global_mark_o, .local_excl_o, .local_addr_o, .local_size_o
);
`default_nettype wire

// ==== mem_model.sv ====
// Memory system model with a global exclusive record.
// Assumes at most one read outstanding at a time.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire [3:0]  delay_i,
    input  wire        req_i,
    input  wire [31:0] addr_i,
    input  wire [2:0]  size_i,
    input  wire        mark_i,
    output reg  [31:0] rdata_o,
    output reg         rvalid_o,
    output reg  [31:0] held_o
);
    reg  [4:0]  wait_q;
    reg  [31:0] addr_q;
    reg  [2:0]  size_q;
    // Narrow data is replicated so any lane choice reads the same value
    wire [31:0] data = (size_q == 3'h1) ? {4{addr_q[7:0] ^ 8'hA5}} :
                       (size_q == 3'h2) ? {2{addr_q[15:0] ^ 16'hC3C3}} : addr_q ^ 32'h5A5A5A5A;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 5'h0;
            addr_q <= 32'h0;
            size_q <= 3'h0;
            rdata_o <= 32'h0;
            rvalid_o <= 1'h0;
            held_o <= 32'h0;
        end else begin
            rvalid_o <= (wait_q == 5'h1);
            // Outside a return the data lines toggle so stale values never match
            rdata_o <= (wait_q == 5'h1) ? data : ~rdata_o;
            if (req_i) begin
                wait_q <= {1'h0, delay_i} + 5'h1;
                addr_q <= addr_i;
                size_q <= size_i;
            end else if (wait_q != 5'h0) begin
                wait_q <= wait_q - 5'h1;
            end
            if (mark_i) held_o <= addr_i;
        end
    end
endmodule // mem_model
`default_nettype wire

// ==== test_load_exec.sv ====
// Self-checking bench for load_exec with a memory model behind it.
// Assumes one operation in flight and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "dual_excl_defs.vh"
module test_load_exec;
    reg         clock_i = 1'h0;
    reg         rst_n_i = 1'h0;
    reg         issue_i = 1'h0;
    reg         condition_check_i = 1'h0;
    reg         mem_shareable_i = 1'h0;
    reg  [31:0] instr_i = 32'h0;
    reg  [31:0] pc_i = 32'h0;
    reg  [31:0] base_value_i = 32'h0;
    reg  [3:0]  delay = 4'h0;
    wire        busy_o, done_o, related_o, unpredictable_o, align_fault_o, mem_req_o, reg_we_o;
    wire        arm_exclusive_monitors_o, global_mark_o, local_excl_o, mem_rvalid_i;
    wire [31:0] mem_addr_o, reg_wdata_o, local_addr_o, mem_rdata_i, held;
    wire [2:0]  mem_size_o, local_size_o;
    wire [3:0]  reg_waddr_o;
    reg  [35:0] wq[$];
    reg  [34:0] aq[$];
    reg  [31:0] tbl [0:7];
    integer     fails = 0, samples_checked = 0, n_unp = 0, n_rel = 0, n_glob = 0, n_flt = 0, k;
    always #25 clock_i = ~clock_i;
    load_exec dut (
        .clock_i, .rst_n_i, .issue_i, .instr_i, .condition_check_i, .pc_i, .base_value_i, .mem_rdata_i,
        .mem_rvalid_i, .mem_shareable_i, .busy_o, .done_o, .related_o, .unpredictable_o, .align_fault_o,
        .mem_req_o, .mem_addr_o, .mem_size_o, .reg_we_o, .reg_waddr_o, .reg_wdata_o, .arm_exclusive_monitors_o,
        .global_mark_o, .local_excl_o, .local_addr_o, .local_size_o
    );
    mem_model mem (.clock_i, .rst_n_i, .delay_i(delay), .req_i(mem_req_o), .addr_i(mem_addr_o), .size_i(mem_size_o),
        .mark_i(global_mark_o), .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i), .held_o(held));
    always @(posedge clock_i) begin
        if (reg_we_o === 1'h1) wq.push_back({reg_waddr_o, reg_wdata_o});
        if (mem_req_o === 1'h1) aq.push_back({mem_size_o, mem_addr_o});
        n_unp = n_unp + (unpredictable_o === 1'h1);
        n_rel = n_rel + (related_o === 1'h1);
        n_glob = n_glob + (global_mark_o === 1'h1);
        n_flt = n_flt + (align_fault_o === 1'h1);
    end
    function [31:0] dual(input [2:0] puw, input [3:0] b, input [3:0] d1, input [3:0] d2, input [7:0] off);
        dual = {d1, d2, off, `OP_DUAL_HI, puw[2], puw[1], 1'h1, puw[0], 1'h1, b};
    endfunction
    function [31:0] xw(input [3:0] b, input [3:0] d1, input [7:0] off);
        xw = {d1, 4'hF, off, `OP_EXCL_WORD, b};
    endfunction
    function [31:0] xn(input [3:0] b, input [3:0] d1, input [3:0] sub);
        xn = {d1, 4'hF, sub, 4'hF, `OP_EXCL_NARROW, b};
    endfunction
    function [31:0] ex(input [2:0] s, input [31:0] a);
        ex = (s == 3'h1) ? {24'h0, a[7:0] ^ 8'hA5} : (s == 3'h2) ? {16'h0, a[15:0] ^ 16'hC3C3} : a ^ 32'h5A5A5A5A;
    endfunction
    task summarize;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [35:0] got, input [35:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chk_acc(input integer i, input [2:0] s, input [31:0] a);
        chk({1'h0, aq[i]}, {1'h0, s, a});
    endtask
    task chk_wr(input integer i, input [3:0] r, input [31:0] d);
        chk(wq[i], {r, d});
    endtask
    task go(input [31:0] ins, input c, input [31:0] b, input [31:0] p, input sh, input fin);
        integer i;
        reg     seen;
        begin
            wq.delete();
            aq.delete();
            {n_unp, n_rel, n_glob, n_flt} = 128'h0;
            seen = 1'h0;
            @(posedge clock_i);
            issue_i <= 1'h1;
            instr_i <= ins;
            condition_check_i <= c;
            base_value_i <= b;
            pc_i <= p;
            mem_shareable_i <= sh;
            @(posedge clock_i);
            issue_i <= 1'h0;
            for (i = 0; i < 60 && !seen; i = i + 1) begin
                @(posedge clock_i);
                seen = (done_o === 1'h1) || (related_o === 1'h1);
            end
            @(negedge clock_i);
            chk(seen, fin);
        end
    endtask
    task dual_chk(input [31:0] a, input [3:0] d1, input [3:0] d2, input [3:0] b, input [31:0] wv, input integer nw);
        begin
            chk_acc(0, 3'h4, a);
            chk_acc(1, 3'h4, a + 32'h4);
            chk_wr(0, d1, ex(3'h4, a));
            chk_wr(1, d2, ex(3'h4, a + 32'h4));
            if (nw == 3) chk_wr(2, b, wv);
            chk(wq.size(), nw);
        end
    endtask
    initial begin
        tbl[0] = dual(3'h5, 4'hF, 4'h1, 4'h2, 8'h01);
        tbl[1] = dual(3'h4, 4'hF, 4'hD, 4'h2, 8'h01);
        tbl[2] = dual(3'h4, 4'hF, 4'h1, 4'hF, 8'h01);
        tbl[3] = dual(3'h4, 4'hF, 4'h3, 4'h3, 8'h01);
        tbl[4] = dual(3'h7, 4'h3, 4'h3, 4'h4, 8'h01);
        tbl[5] = xw(4'h2, 4'hD, 8'h00);
        tbl[6] = xn(4'h2, 4'hF, `OP_EXCL_SUB_BYTE);
        tbl[7] = xn(4'hF, 4'h1, `OP_EXCL_SUB_HALF);
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'h1;
        delay <= 4'h3;
        go(dual(3'h5, 4'h4, 4'h1, 4'h2, 8'h02), 1'h1, 32'h1000, 32'h0, 1'h0, 1'h1);
        dual_chk(32'hFF8, 4'h1, 4'h2, 4'h4, 32'hFF8, 3);
        delay <= 4'h0;
        go(dual(3'h3, 4'h5, 4'h6, 4'h7, 8'hFF), 1'h1, 32'h2000, 32'h0, 1'h0, 1'h1);
        dual_chk(32'h2000, 4'h6, 4'h7, 4'h5, 32'h23FC, 3);
        go(dual(3'h6, 4'h5, 4'h6, 4'h7, 8'h01), 1'h1, 32'h2000, 32'h0, 1'h0, 1'h1);
        dual_chk(32'h2004, 4'h6, 4'h7, 4'h0, 32'h0, 2);
        go(dual(3'h2, 4'h5, 4'h6, 4'h7, 8'h01), 1'h1, 32'h2000, 32'h0, 1'h0, 1'h1);
        chk(n_rel + aq.size(), 1);
        go(dual(3'h4, 4'hF, 4'h1, 4'h2, 8'h10), 1'h1, 32'h1234, 32'h8000, 1'h0, 1'h1);
        dual_chk(32'h7FC0, 4'h1, 4'h2, 4'h0, 32'h0, 2);
        chk(n_unp, 0);
        go(dual(3'h6, 4'hF, 4'h1, 4'h2, 8'hFF), 1'h1, 32'h1234, 32'h8000, 1'h0, 1'h1);
        dual_chk(32'h83FC, 4'h1, 4'h2, 4'h0, 32'h0, 2);
        go(dual(3'h6, 4'hF, 4'h1, 4'h2, 8'h00), 1'h1, 32'h0, 32'h8002, 1'h0, 1'h1);
        chk(n_flt * 2 + aq.size(), 2);
        chk(n_unp, 1);
        go(xw(4'h3, 4'h9, 8'h03), 1'h0, 32'h3000, 32'h0, 1'h1, 1'h0);
        chk(aq.size() + wq.size(), 0);
        go(xw(4'h3, 4'h9, 8'h03), 1'h1, 32'h3000, 32'h0, 1'h1, 1'h1);
        chk_acc(0, `SIZE_WORD, 32'h300C);
        chk_wr(0, 4'h9, ex(3'h4, 32'h300C));
        chk({n_glob[3:0], held}, {4'h1, 32'h300C});
        chk({local_excl_o, local_size_o, local_addr_o}, {1'h1, `SIZE_WORD, 32'h300C});
        go(xn(4'h3, 4'hA, `OP_EXCL_SUB_BYTE), 1'h1, 32'h4003, 32'h0, 1'h0, 1'h1);
        chk_acc(0, `SIZE_BYTE, 32'h4003);
        chk_wr(0, 4'hA, ex(3'h1, 32'h4003));
        chk(n_glob, 0);
        chk({local_excl_o, local_size_o, local_addr_o}, {1'h1, `SIZE_BYTE, 32'h4003});
        go(xn(4'h3, 4'hB, `OP_EXCL_SUB_HALF), 1'h1, 32'h5002, 32'h0, 1'h1, 1'h1);
        chk_acc(0, `SIZE_HALF, 32'h5002);
        chk_wr(0, 4'hB, ex(3'h2, 32'h5002));
        chk(n_glob, 1);
        go(xn(4'h3, 4'hB, `OP_EXCL_SUB_HALF), 1'h1, 32'h5001, 32'h0, 1'h0, 1'h1);
        chk(n_flt * 2 + aq.size(), 2);
        for (k = 0; k < 8; k = k + 1) begin
            go(tbl[k], 1'h1, 32'h6000, 32'h9000, 1'h0, 1'h1);
            chk(n_unp, 1);
        end
        summarize;
    end
    // Generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        #150000;
        fails = fails + 1;
        summarize;
    end
endmodule // test_load_exec
`default_nettype wire
